/* logic/hgp_pkg.sv */
// Package with register map, reset values and bus carrier types for the GPIO port
package hgp_pkg;
  localparam int unsigned PIN_COUNT = 29;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_OUTPUT_DATA = 12'h000;
  localparam logic [11:0] OFS_DIRECTION = 12'h004;
  localparam logic [11:0] OFS_PIN_INPUT = 12'h050;
  localparam logic [31:0] RST_OUTPUT_DATA = 32'h0000_0000;
  localparam logic [31:0] RST_DIRECTION = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  localparam int unsigned LED_BIT = 24;
  localparam int unsigned KEY_BIT = 25;
  localparam int unsigned FIRST_LINE = 29;

  typedef struct packed {
    logic read;
    logic write;
    logic [11:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } hgp_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } hgp_rsp_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_OUT = 2'b01,
    SEL_DIR = 2'b10,
    SEL_IN = 2'b11
  } hgp_sel_t;
endpackage : hgp_pkg

/* logic/hgp_sync.sv */
// Two-flop synchroniser bank for the pin inputs
module hgp_sync #(
  parameter int unsigned WIDTH = 29
) (
  input wire logic mclk, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic [WIDTH-1:0] d_async, // Raw pin levels
  output logic [WIDTH-1:0] q_sync // Synchronised levels
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      meta_reg <= '0;
      q_sync <= '0;
    end
    else
    begin
      meta_reg <= d_async;
      q_sync <= meta_reg;
    end
  end
endmodule : hgp_sync

/* logic/hgp_pad.sv */
// Per-pin output driver and enable stage
module hgp_pad #(
  parameter int unsigned WIDTH = 29
) (
  input wire logic [WIDTH-1:0] out_level, // Level to drive
  input wire logic [WIDTH-1:0] dir_out, // 1 = pin is output
  output logic [WIDTH-1:0] pin_o, // Pin output value
  output logic [WIDTH-1:0] pin_oe // Pin output enable
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_pin
      // Data stays parked on pin_o; only the enable gates the pin
      assign pin_oe[g] = dir_out[g];
      assign pin_o[g] = out_level[g];
    end
  endgenerate
endmodule : hgp_pad

/* logic/hgp_port.sv */
// Top of the GPIO port controller: Avalon-MM slave, registers and pin stage
//
// Design decisions made here: the register addresses and register access over Avalon-MM.

// What this block does
// - Three 32-bit registers: output data, direction, read-only pin input.
// - Direction bit n sets pin n; 1 is output, 0 is input.
// - Output data bit n sets driven level; 1 high, 0 low.
// - Pin input read returns each pin level in its bit position.
// - Bit 0 is the port's lowest pin, line 29; upward to line 57.
// - Bit 24 is the indicator light, bit 25 the push-button.
// - Registers sit in a 4 KB window decoded from the base address.
module hgp_port #(
  parameter int unsigned PINS = hgp_pkg::PIN_COUNT
) (
  input wire logic mclk, // 40 MHz clock
  input wire logic reset, // Async reset, active high
  input wire logic avs_chipselect, // Base-address window select from interconnect
  input wire logic [11:0] avs_address, // Byte offset inside 4 KB window
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [3:0] avs_byteenable, // Byte lanes of a write
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall, low when access completes
  input wire logic [PINS-1:0] pin_i, // Pin levels in
  output logic [PINS-1:0] pin_o, // Pin drive levels
  output logic [PINS-1:0] pin_oe // Pin output enables
);
  hgp_pkg::hgp_req_t req;
  hgp_pkg::hgp_rsp_t rsp;
  logic [31:0] out_data_reg;
  logic [31:0] out_data_next;
  logic [31:0] dir_reg;
  logic [31:0] dir_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ack_reg;
  logic [PINS-1:0] pin_sync;
  logic [31:0] pin_word;
  logic [31:0] be_mask;
  hgp_pkg::hgp_sel_t sel;
  wire access = req.read | req.write;
  wire do_write = req.write & ~ack_reg;
  wire do_read = req.read & ~ack_reg;
  // Named selects keep the register logic and the checks on one decode
  wire wr_out = do_write & (sel == hgp_pkg::SEL_OUT);
  wire wr_dir = do_write & (sel == hgp_pkg::SEL_DIR);
  wire rd_out = do_read & (sel == hgp_pkg::SEL_OUT);
  wire rd_dir = do_read & (sel == hgp_pkg::SEL_DIR);
  wire rd_in = do_read & (sel == hgp_pkg::SEL_IN);
  wire rd_none = do_read & (sel == hgp_pkg::SEL_NONE);

  assign req.read = avs_read & avs_chipselect;
  assign req.write = avs_write & avs_chipselect;
  assign req.address = avs_address;
  assign req.byteenable = avs_byteenable;
  assign req.writedata = avs_writedata;

  function automatic hgp_pkg::hgp_sel_t decode(input logic [11:0] a);
    // Only the low 12 bits reach us: the interconnect decodes the base
    if (a == hgp_pkg::OFS_OUTPUT_DATA)
      decode = hgp_pkg::SEL_OUT;
    else if (a == hgp_pkg::OFS_DIRECTION)
      decode = hgp_pkg::SEL_DIR;
    else if (a == hgp_pkg::OFS_PIN_INPUT)
      decode = hgp_pkg::SEL_IN;
    else
      decode = hgp_pkg::SEL_NONE;
  endfunction : decode

  // Byte lanes with a clear enable keep their stored value
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_word,
    input logic [31:0] new_word, input logic [31:0] mask);
    merge_lanes = (old_word & ~mask) | (new_word & mask);
  endfunction : merge_lanes

  assign sel = decode(req.address);
  assign be_mask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                    {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};

  hgp_sync #(.WIDTH(PINS)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .d_async(pin_i),
    .q_sync(pin_sync)
  );

  // Unserved upper bits read as zero
  assign pin_word = {{(32-PINS){1'b0}}, pin_sync};

  assign out_data_next = wr_out ?
    merge_lanes(out_data_reg, req.writedata, be_mask) : out_data_reg;
  assign dir_next = wr_dir ?
    merge_lanes(dir_reg, req.writedata, be_mask) : dir_reg;
  assign rdata_next = !do_read ? rdata_reg :
    (sel == hgp_pkg::SEL_OUT) ? out_data_reg :
    (sel == hgp_pkg::SEL_DIR) ? dir_reg :
    (sel == hgp_pkg::SEL_IN) ? pin_word : hgp_pkg::UNMAPPED_READ;

  // One short process per register keeps each reset branch plain
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      out_data_reg <= hgp_pkg::RST_OUTPUT_DATA;
    else
      out_data_reg <= out_data_next;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      dir_reg <= hgp_pkg::RST_DIRECTION;
    else
      dir_reg <= dir_next;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= rdata_next;
  end

  // One wait cycle gives registered read data; ack drops after completion
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      ack_reg <= 1'b0;
    else
      ack_reg <= access & ~ack_reg;
  end

  assign rsp.waitrequest = access & ~ack_reg;
  assign rsp.readdata = rdata_reg;
  assign avs_waitrequest = rsp.waitrequest;
  assign avs_readdata = rsp.readdata;

  // Bits above the served pins are stored but never reach a pin
  hgp_pad #(.WIDTH(PINS)) u_pad (
    .out_level(out_data_reg[PINS-1:0]),
    .dir_out(dir_reg[PINS-1:0]),
    .pin_o(pin_o),
    .pin_oe(pin_oe)
  );

  property p_oe_follows_dir;
    @(posedge mclk) disable iff (reset)
    pin_oe == dir_reg[PINS-1:0];
  endproperty
  dir_gates_oe_a: assert property (p_oe_follows_dir)
    else $error("pin enable differs from direction");

  input_undriven_a: assert property (@(posedge mclk) disable iff (reset)
    (wr_dir && req.byteenable == 4'hF && req.writedata[PINS-1:0] == '0) |=>
      (pin_oe == '0))
    else $error("input pin driven");

  out_write_a: assert property (@(posedge mclk) disable iff (reset)
    (do_write && sel == hgp_pkg::SEL_OUT && req.byteenable == 4'hF) |=>
      (pin_o == $past(req.writedata[PINS-1:0])))
    else $error("output level not updated by write");

  dir_write_a: assert property (@(posedge mclk) disable iff (reset)
    (do_write && sel == hgp_pkg::SEL_DIR && req.byteenable == 4'hF) |=>
      (dir_reg == $past(req.writedata)))
    else $error("direction not updated");

  in_read_a: assert property (@(posedge mclk) disable iff (reset)
    (do_read && sel == hgp_pkg::SEL_IN) |=>
      (!avs_waitrequest && avs_readdata == {{(32-PINS){1'b0}}, $past(pin_sync)}))
    else $error("pin input read wrong");

  led_pin_a: assert property (@(posedge mclk) disable iff (reset)
    (wr_out && req.byteenable[3]) |=>
      (pin_o[hgp_pkg::LED_BIT] == $past(req.writedata[hgp_pkg::LED_BIT])))
    else $error("indicator bit mismatch");

  ro_input_a: assert property (@(posedge mclk) disable iff (reset)
    (do_write && sel == hgp_pkg::SEL_IN) |=> $stable(out_data_reg) && $stable(dir_reg))
    else $error("write to input register changed state");

  unmapped_zero_a: assert property (@(posedge mclk) disable iff (reset)
    (do_read && sel == hgp_pkg::SEL_NONE) |=> (avs_readdata == 32'h0000_0000))
    else $error("unmapped read not zero");

  one_wait_a: assert property (@(posedge mclk) disable iff (reset)
    (access && !ack_reg) |-> avs_waitrequest ##1 (!avs_waitrequest || !access))
    else $error("waitrequest longer than one cycle");

  // Register hold, read-back, wait-state and pin enable checks
  property p_dir_hold;
    @(posedge mclk) disable iff (reset)
    !wr_dir |=> $stable(dir_reg);
  endproperty
  dir_hold_a: assert property (p_dir_hold)
    else $error("direction changed without a write");

  property p_out_hold;
    @(posedge mclk) disable iff (reset)
    !wr_out |=> $stable(out_data_reg);
  endproperty
  out_hold_a: assert property (p_out_hold)
    else $error("output data changed without a write");

  property p_out_read;
    @(posedge mclk) disable iff (reset)
    rd_out |=> (avs_readdata == $past(out_data_reg));
  endproperty
  out_read_a: assert property (p_out_read)
    else $error("output data read back wrong");

  property p_dir_read;
    @(posedge mclk) disable iff (reset)
    rd_dir |=> (avs_readdata == $past(dir_reg));
  endproperty
  dir_read_a: assert property (p_dir_read)
    else $error("direction read back wrong");

  property p_rdata_hold;
    @(posedge mclk) disable iff (reset)
    !do_read |=> $stable(avs_readdata);
  endproperty
  rdata_hold_a: assert property (p_rdata_hold)
    else $error("read data moved without a read");

  property p_idle_ready;
    @(posedge mclk) disable iff (reset)
    !access |-> !avs_waitrequest;
  endproperty
  idle_ready_a: assert property (p_idle_ready)
    else $error("waitrequest high while idle");

  property p_ack_pulse;
    @(posedge mclk) disable iff (reset)
    ack_reg |=> !ack_reg;
  endproperty
  ack_pulse_a: assert property (p_ack_pulse)
    else $error("completion held longer than one cycle");

  property p_unmapped_write;
    @(posedge mclk) disable iff (reset)
    (do_write && sel == hgp_pkg::SEL_NONE) |=> ($stable(out_data_reg) && $stable(dir_reg));
  endproperty
  unmapped_wr_a: assert property (p_unmapped_write)
    else $error("unmapped write changed state");

  property p_refused_wait;
    @(posedge mclk) disable iff (reset)
    rd_none |-> avs_waitrequest;
  endproperty
  refused_wait_a: assert property (p_refused_wait)
    else $error("unmapped read skipped its wait state");

  property p_write_wait;
    @(posedge mclk) disable iff (reset)
    do_write |-> avs_waitrequest;
  endproperty
  write_wait_a: assert property (p_write_wait)
    else $error("write skipped its wait state");

  property p_upper_zero;
    @(posedge mclk) disable iff (reset)
    rd_in |=> (avs_readdata[31:PINS] == '0);
  endproperty
  upper_zero_a: assert property (p_upper_zero)
    else $error("unserved input bits not zero");

  property p_line_zero;
    @(posedge mclk) disable iff (reset)
    rd_in |=> (avs_readdata[0] == $past(pin_sync[0]));
  endproperty
  line_zero_a: assert property (p_line_zero)
    else $error("lowest pin not at bit zero");

  property p_key_read;
    @(posedge mclk) disable iff (reset)
    rd_in |=> (avs_readdata[hgp_pkg::KEY_BIT] == $past(pin_sync[hgp_pkg::KEY_BIT]));
  endproperty
  key_read_a: assert property (p_key_read)
    else $error("push-button bit read wrong");

  property p_oe_write;
    @(posedge mclk) disable iff (reset)
    (wr_dir && req.byteenable == 4'hF) |=> (pin_oe == $past(req.writedata[PINS-1:0]));
  endproperty
  oe_write_a: assert property (p_oe_write)
    else $error("pin enables not set by direction write");

  // Per-lane hold: a cleared byte enable must protect its byte
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++)
    begin : g_lane_chk
      lane_keep_a: assert property (@(posedge mclk) disable iff (reset)
        (wr_out && !req.byteenable[lane]) |=>
          (out_data_reg[8*lane +: 8] == $past(out_data_reg[8*lane +: 8])))
        else $error("disabled byte lane written");
    end
  endgenerate

  // One cover per main traffic kind
  wr_out_c: cover property (@(posedge mclk) do_write && sel == hgp_pkg::SEL_OUT);
  wr_dir_c: cover property (@(posedge mclk) do_write && sel == hgp_pkg::SEL_DIR);
  rd_in_c: cover property (@(posedge mclk) do_read && sel == hgp_pkg::SEL_IN);
  key_high_c: cover property (@(posedge mclk) pin_sync[hgp_pkg::KEY_BIT]);
  lane_wr_c: cover property (@(posedge mclk) wr_out && req.byteenable != 4'hF);
endmodule : hgp_port

/* test/hgp_board.sv */
// Board model: indicator light and push-button on the port pins
module hgp_board (
  input wire logic [28:0] pin_o, // Port drive levels
  input wire logic [28:0] pin_oe, // Port drive enables
  input wire logic key_level, // Push-button, 1 = released
  input wire logic [28:0] ext_level, // Other board lines
  output logic [28:0] pin_i, // Wire levels seen by port
  output logic led_level // Indicator light level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [28:0] far;
  assign far = {ext_level[28:26], key_level, ext_level[24:0]};
  // A driven pin shows the port level, an undriven one the board level
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & far);
  assign led_level = pin_i[24];
endmodule : hgp_board

/* test/test_hgp_port.sv */
// Bench for the GPIO port: register access and pin levels
module test_hgp_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset, cs, rq_rd, rq_wr, wt, key_level, led_level;
  logic [11:0] adr;
  logic [3:0] be;
  logic [31:0] wd, rdat;
  logic [28:0] pin_i, pin_o, pin_oe, ext_level;
  int fails, n_tests;
  hgp_port dut (.mclk(mclk), .reset(reset), .avs_chipselect(cs), .avs_address(adr),
    .avs_read(rq_rd), .avs_write(rq_wr), .avs_byteenable(be), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wt), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe));
  hgp_board board (.pin_o(pin_o), .pin_oe(pin_oe), .key_level(key_level),
    .ext_level(ext_level), .pin_i(pin_i), .led_level(led_level));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] lanes);
    cs <= 1'b1;
    rq_wr <= 1'b1;
    adr <= a;
    wd <= d;
    be <= lanes;
    do @(posedge mclk); while (wt !== 1'b0);
    cs <= 1'b0;
    rq_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task rchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    cs <= 1'b1;
    rq_rd <= 1'b1;
    adr <= a;
    do @(posedge mclk); while (wt !== 1'b0);
    q = rdat;
    cs <= 1'b0;
    rq_rd <= 1'b0;
    @(posedge mclk);
    chk(nm, q, exp);
  endtask : rchk
  initial
  begin
    repeat (3000) @(posedge mclk);
    fails++;
    report_and_stop;
  end
  initial
  begin
    reset = 1'b1;
    {cs, rq_rd, rq_wr} = 3'h0;
    adr = 12'h000;
    be = 4'h0;
    wd = 32'h0000_0000;
    ext_level = 29'h0000_0000;
    key_level = 1'b0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk("oe at reset", 32'(pin_oe), 32'h0000_0000);
    rchk(hgp_pkg::OFS_OUTPUT_DATA, hgp_pkg::RST_OUTPUT_DATA, "out reset");
    rchk(hgp_pkg::OFS_DIRECTION, hgp_pkg::RST_DIRECTION, "dir reset");
    // Walking one over every line, key included at bit 25
    for (int i = 0; i < 29; i++)
    begin
      ext_level <= 29'(1) << i;
      key_level <= (i == 25);
      repeat (3) @(posedge mclk);
      rchk(hgp_pkg::OFS_PIN_INPUT, 32'h1 << i, "pin walk");
    end
    ext_level <= 29'h0000_0000;
    key_level <= 1'b0;
    wr(hgp_pkg::OFS_DIRECTION, 32'hE100_0000, 4'hF);
    wr(hgp_pkg::OFS_OUTPUT_DATA, 32'hFFFF_FFFF, 4'hF);
    wr(hgp_pkg::OFS_OUTPUT_DATA, 32'h0000_0000, 4'h1);
    chk("oe", 32'(pin_oe), 32'h0100_0000);
    chk("drive", 32'(pin_o), 32'h1FFF_FF00);
    chk("light", 32'(led_level), 32'h1);
    rchk(hgp_pkg::OFS_DIRECTION, 32'hE100_0000, "dir back");
    rchk(hgp_pkg::OFS_OUTPUT_DATA, 32'hFFFF_FF00, "out lanes");
    rchk(hgp_pkg::OFS_PIN_INPUT, 32'h0100_0000, "key pressed");
    key_level <= 1'b1;
    wr(hgp_pkg::OFS_PIN_INPUT, 32'hFFFF_FFFF, 4'hF);
    wr(12'h008, 32'hFFFF_FFFF, 4'hF);
    rchk(hgp_pkg::OFS_PIN_INPUT, 32'h0300_0000, "key released");
    rchk(12'h008, hgp_pkg::UNMAPPED_READ, "unmapped");
    rchk(12'hFFC, hgp_pkg::UNMAPPED_READ, "window top");
    wr(hgp_pkg::OFS_DIRECTION, 32'h0000_0000, 4'hF);
    chk("oe off", 32'(pin_oe), 32'h0000_0000);
    rchk(hgp_pkg::OFS_OUTPUT_DATA, 32'hFFFF_FF00, "out kept");
    wr(hgp_pkg::OFS_DIRECTION, 32'h0000_01FF, 4'hF);
    chk("oe low", 32'(pin_oe), 32'h0000_01FF);
    repeat (3) @(posedge mclk);
    rchk(hgp_pkg::OFS_PIN_INPUT, 32'h0200_0100, "reapplied");
    // Mid-run reset must drop every drive and clear both registers
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("oe in reset", 32'(pin_oe), 32'h0000_0000);
    reset <= 1'b0;
    @(posedge mclk);
    rchk(hgp_pkg::OFS_OUTPUT_DATA, hgp_pkg::RST_OUTPUT_DATA, "out re-reset");
    rchk(hgp_pkg::OFS_DIRECTION, hgp_pkg::RST_DIRECTION, "dir re-reset");
    report_and_stop;
  end
endmodule : test_hgp_port
